// ---- dv/dqi_bb_model.sv ----
// Baseband sample source model feeding the impairment block
`timescale 1ns/10ps
module dqi_bb_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic burst,
	input wire logic fire,
	input wire logic signed [15:0] i_lvl,
	input wire logic signed [15:0] q_lvl,
	output logic valid,
	output logic mark,
	output logic signed [15:0] i_smp,
	output logic signed [15:0] q_smp
);
	typedef struct packed {
		logic valid;
		logic mark;
		logic signed [15:0] i;
		logic signed [15:0] q;
	} dqi_bb_st_t;

	dqi_bb_st_t st_reg;
	dqi_bb_st_t st_next;
	logic live;

	// ==========================================================
	// Steady stream, or zeros with one marked pair per fire
	assign live = !burst || fire;

	always_comb begin
		st_next.valid = live;
		st_next.mark = burst && fire;
		st_next.i = live ? i_lvl : 16'sh0000;
		st_next.q = live ? q_lvl : 16'sh0000;
	end

	always_ff @(posedge clk) begin
		st_reg <= srst ? '0 : st_next;
	end

	assign valid = st_reg.valid;
	assign mark = st_reg.mark;
	assign i_smp = st_reg.i;
	assign q_smp = st_reg.q;
endmodule : dqi_bb_model

// ---- dv/dqi_top_tb.sv ----
// Self-checking bench of the digital I/Q impairment block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module dqi_top_tb import dqi_pkg::*;;
	logic clk, srst, wr, rd, burst, fire;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic valid_in, mark_in, valid_out, mark_out;
	logic signed [15:0] i_in, q_in, i_out, q_out, i_lvl, q_lvl;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;

	dqi_top u_dqi_top (.REF_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .VALID_IN(valid_in), .I_IN(i_in), .Q_IN(q_in),
		.MARK_IN(mark_in), .VALID_OUT(valid_out), .I_OUT(i_out), .Q_OUT(q_out),
		.MARK_OUT(mark_out));
	dqi_bb_model u_dqi_bb_model (.clk(clk), .srst(srst), .burst(burst), .fire(fire),
		.i_lvl(i_lvl), .q_lvl(q_lvl), .valid(valid_in), .mark(mark_in), .i_smp(i_in),
		.q_smp(q_in));

	// ==========================================================
	// Closing report, bus tasks and level stimulus task
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	task automatic drive_lvl(input logic signed [15:0] i, input logic signed [15:0] q);
		i_lvl <= i;
		q_lvl <= q;
		repeat (20) @(posedge clk);
		@(negedge clk);
	endtask : drive_lvl

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [31:0] v;
		rd_reg(DQI_CTRL_ADDR, v);
		`CHK("ctrl", 32'h0000_0000, v);
		rd_reg(DQI_LEAK_I_ADDR, v);
		`CHK("leak_i", 32'h0000_0000, v);
		rd_reg(DQI_IMB_ADDR, v);
		`CHK("imb", 32'h0000_0000, v);
		rd_reg(8'h2c, v);
		`CHK("unmapped", 32'h0000_0000, v);
		wr_reg(DQI_LEAK_Q_ADDR, 32'h0000_1234);
		rd_reg(DQI_LEAK_Q_ADDR, v);
		`CHK("leak_q", 32'h0000_1234, v);
		wr_reg(DQI_LEAK_Q_ADDR, 32'h0000_0000);
	endtask : t_regs

	task automatic t_disabled;
		wr_reg(DQI_PD_I_ADDR, 32'h0000_0064);
		wr_reg(DQI_PD_Q_ADDR, 32'h0000_0032);
		wr_reg(DQI_LEAK_I_ADDR, 32'h0000_03e8);
		wr_reg(DQI_IMB_ADDR, 32'h0000_0003);
		wr_reg(DQI_QUAD_ADDR, 32'h0000_0800);
		drive_lvl(16'sh03e8, 16'sh03e8);
		`CHK("i_off", 16'sh044c, i_out);
		`CHK("q_off", 16'sh041a, q_out);
		wr_reg(DQI_PD_I_ADDR, 32'h0000_0000);
		wr_reg(DQI_PD_Q_ADDR, 32'h0000_0000);
		wr_reg(DQI_IMB_ADDR, 32'h0000_0000);
		wr_reg(DQI_QUAD_ADDR, 32'h0000_0000);
	endtask : t_disabled

	task automatic t_leak;
		wr_reg(DQI_CTRL_ADDR, 32'h0000_0001);
		drive_lvl(16'sh03e8, 16'sh03e8);
		`CHK("i_leak", 16'sh10b4, i_out);
		`CHK("q_noleak", 16'sh03e8, q_out);
		wr_reg(DQI_LEAK_I_ADDR, 32'h0000_0000);
		wr_reg(DQI_LEAK_Q_ADDR, 32'h0000_03e8);
		drive_lvl(16'sh03e8, 16'sh03e8);
		`CHK("i_noleak", 16'sh03e8, i_out);
		`CHK("q_leak", 16'sh10b4, q_out);
		wr_reg(DQI_LEAK_Q_ADDR, 32'h0000_0000);
	endtask : t_leak

	task automatic t_imb;
		logic [31:0] iv [2];
		logic signed [15:0] qe [2];
		iv = '{32'h0000_0001, 32'h0000_00ff};
		qe = '{16'sh0462, 16'sh037b};
		for (int k = 0; k < 2; k++) begin
			wr_reg(DQI_IMB_ADDR, iv[k]);
			drive_lvl(16'sh0000, 16'sh03e8);
			`CHK("q_gain", qe[k], q_out);
			drive_lvl(16'sh03e8, 16'sh0000);
			`CHK("i_gain", 16'sh03e8, i_out);
		end
		wr_reg(DQI_CTRL_ADDR, 32'h0000_0003);
		wr_reg(DQI_IMB_ADDR, 32'h0000_000c);
		drive_lvl(16'sh0000, 16'sh03e8);
		`CHK("q_pct", 16'sh0460, q_out);
		wr_reg(DQI_CTRL_ADDR, 32'h0000_0001);
		wr_reg(DQI_IMB_ADDR, 32'h0000_0000);
	endtask : t_imb

	task automatic t_quad_phase;
		wr_reg(DQI_QUAD_ADDR, 32'h0000_0800);
		drive_lvl(16'sh03e8, 16'sh0000);
		`CHK("i_quad", 16'sh03e8, i_out);
		`CHK("q_quad", 16'shff83, q_out);
		wr_reg(DQI_QUAD_ADDR, 32'h0000_0000);
		wr_reg(DQI_LEAK_I_ADDR, 32'h0000_03e8);
		wr_reg(DQI_PHASE_ADDR, 32'h0000_0004);
		drive_lvl(16'sh0000, 16'sh0000);
		`CHK("i_rot", 16'sh0000, i_out);
		`CHK("q_rot", 16'sh0ccc, q_out);
		wr_reg(DQI_PHASE_ADDR, 32'h0000_0000);
		wr_reg(DQI_LEAK_I_ADDR, 32'h0000_0000);
	endtask : t_quad_phase

	task automatic t_timing;
		logic [31:0] sk [6];
		logic [31:0] dl [6];
		logic [31:0] v;
		int ei [6];
		int eq [6];
		int ti, tq, tm, tv;
		sk = '{32'h0, 32'h2, 32'hffff_fffe, 32'h0, 32'h0, 32'h0};
		dl = '{32'h0, 32'h0, 32'h0, 32'h2, 32'hffff_fffe, 32'h8};
		ei = '{12, 11, 13, 14, 10, 4};
		eq = '{12, 13, 11, 14, 10, 4};
		burst <= 1'b1;
		drive_lvl(16'sh03e8, 16'sh03e8);
		for (int k = 0; k < 6; k++) begin
			wr_reg(DQI_SKEW_ADDR, sk[k]);
			wr_reg(DQI_DELAY_ADDR, dl[k]);
			rd_reg(DQI_STAT_ADDR, v);
			`CHK("status", 32'(1 + ((ei[k] - 4) << 1) + ((eq[k] - 4) << 5)), v);
			repeat (4) @(posedge clk);
			fire <= 1'b1;
			@(posedge clk);
			fire <= 1'b0;
			@(negedge clk);
			{ti, tq, tm, tv} = '0;
			for (int n = 1; n <= 20; n++) begin
				@(negedge clk);
				if (ti == 0 && i_out !== 16'sh0000) ti = n;
				if (tq == 0 && q_out !== 16'sh0000) tq = n;
				if (tm == 0 && mark_out === 1'b1) tm = n;
				if (tv == 0 && valid_out === 1'b1) tv = n;
			end
			`CHK("i_time", ei[k], ti);
			`CHK("q_time", eq[k], tq);
			`CHK("mark_time", 12, tm);
			`CHK("valid_time", 12, tv);
		end
	endtask : t_timing

	task automatic t_reset_mid;
		logic [31:0] v;
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd_reg(DQI_CTRL_ADDR, v);
		`CHK("ctrl_rst", 32'h0000_0000, v);
		rd_reg(DQI_DELAY_ADDR, v);
		`CHK("dly_rst", 32'h0000_0000, v);
	endtask : t_reset_mid

	// ==========================================================
	// Clock, timeout and main sequence
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		{srst, wr, rd, burst, fire} = 5'h10;
		{addr, wdata, i_lvl, q_lvl} = '0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (20) @(posedge clk);
		t_regs();
		t_disabled();
		t_leak();
		t_imb();
		t_quad_phase();
		t_timing();
		t_reset_mid();
		complete_run();
	end
endmodule : dqi_top_tb

// ---- src/dqi_dly.sv ----
// Tapped sample delay line of the digital I/Q impairment block
`timescale 1ns/10ps
module dqi_dly import dqi_pkg::*; #(
	parameter int W = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic signed [W-1:0] din,
	input wire logic [AW-1:0] tap,
	output logic signed [W-1:0] dout
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic primed;
	} dqi_dly_st_t;

	dqi_dly_st_t st_reg;
	dqi_dly_st_t st_next;

	// ==========================================================
	// Shift chain, one sample per clock
	always_comb begin
		st_next = st_reg;
		st_next.mem[0] = din;
		for (int k = 1; k < DEPTH; k++) begin
			st_next.mem[k] = st_reg.mem[k-1];
		end
		st_next.primed = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.mem[tap];

	// ==========================================================
	// Checks
	tap_zero_a: assert property (@(posedge clk) disable iff (srst)
		(st_reg.primed && tap == '0) |-> (dout == $past(din)))
		else $error("tap zero is not a one-cycle delay");

endmodule : dqi_dly

// ---- src/dqi_pkg.sv ----
// Constants, register map and helper functions of the digital I/Q impairment block
package dqi_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] DQI_CTRL_ADDR = 8'h00;
	localparam logic [7:0] DQI_LEAK_I_ADDR = 8'h04;
	localparam logic [7:0] DQI_LEAK_Q_ADDR = 8'h08;
	localparam logic [7:0] DQI_IMB_ADDR = 8'h0c;
	localparam logic [7:0] DQI_QUAD_ADDR = 8'h10;
	localparam logic [7:0] DQI_SKEW_ADDR = 8'h14;
	localparam logic [7:0] DQI_DELAY_ADDR = 8'h18;
	localparam logic [7:0] DQI_PHASE_ADDR = 8'h1c;
	localparam logic [7:0] DQI_PD_I_ADDR = 8'h20;
	localparam logic [7:0] DQI_PD_Q_ADDR = 8'h24;
	localparam logic [7:0] DQI_STAT_ADDR = 8'h28;

	// ==========================================================
	// Field positions
	localparam int DQI_CTRL_EN_BIT = 0;
	localparam int DQI_CTRL_PCT_BIT = 1;
	localparam int DQI_STAT_EN_BIT = 0;
	localparam int DQI_STAT_TI_POS = 1;
	localparam int DQI_STAT_TQ_POS = 5;

	// ==========================================================
	// Reset values
	localparam logic DQI_EN_RST = 1'b0;
	localparam logic [31:0] DQI_SET_RST = 32'h0000_0000;

	// ==========================================================
	// Timing and scaling
	localparam int DQI_BASE_TAP = 8;
	localparam int DQI_LAT = DQI_BASE_TAP + 4;
	localparam logic signed [17:0] DQI_UNITY = 18'sh04000;
	localparam logic signed [17:0] DQI_PCT_STEP = 18'sh000a4;
	localparam logic signed [18:0] DQI_LEAK_SCALE = 19'sh346d6;

	typedef enum logic {DQI_UNIT_DB, DQI_UNIT_PCT} dqi_unit_t;

	// ==========================================================
	// Linear gain for whole dB from -8 to +7
	function automatic logic signed [17:0] dqi_db_gain(input logic signed [7:0] db);
		logic [3:0] k;
		k = (db < -8'sd8) ? 4'h8 : (db > 8'sd7) ? 4'h7 : db[3:0];
		case (k)
			4'h8: dqi_db_gain = 18'sh0197b;
			4'h9: dqi_db_gain = 18'sh01c97;
			4'ha: dqi_db_gain = 18'sh02013;
			4'hb: dqi_db_gain = 18'sh023fd;
			4'hc: dqi_db_gain = 18'sh02862;
			4'hd: dqi_db_gain = 18'sh02d4f;
			4'he: dqi_db_gain = 18'sh032d6;
			4'hf: dqi_db_gain = 18'sh0390a;
			4'h0: dqi_db_gain = 18'sh04000;
			4'h1: dqi_db_gain = 18'sh047cf;
			4'h2: dqi_db_gain = 18'sh05092;
			4'h3: dqi_db_gain = 18'sh05a67;
			4'h4: dqi_db_gain = 18'sh0656f;
			4'h5: dqi_db_gain = 18'sh071cf;
			4'h6: dqi_db_gain = 18'sh07fb2;
			default: dqi_db_gain = 18'sh08f47;
		endcase
	endfunction : dqi_db_gain

	// Sine in 22.5 degree steps
	function automatic logic signed [17:0] dqi_sin(input logic [3:0] k);
		logic [2:0] m;
		logic signed [17:0] s;
		m = (k[2:0] > 3'h4) ? 3'(4'h8 - {1'b0, k[2:0]}) : k[2:0];
		case (m)
			3'h0: s = 18'sh00000;
			3'h1: s = 18'sh0187e;
			3'h2: s = 18'sh02d41;
			3'h3: s = 18'sh03b21;
			default: s = 18'sh04000;
		endcase
		dqi_sin = k[3] ? -s : s;
	endfunction : dqi_sin

	// Clamp to signed 16 bit
	function automatic logic signed [15:0] dqi_sat16(input logic signed [24:0] v);
		if (v > 25'sd32767) begin
			dqi_sat16 = 16'sh7fff;
		end else if (v < -25'sd32768) begin
			dqi_sat16 = 16'sh8000;
		end else begin
			dqi_sat16 = v[15:0];
		end
	endfunction : dqi_sat16

endpackage : dqi_pkg

// ---- src/dqi_top.sv ----
// Digital I/Q impairment datapath with register port
`timescale 1ns/10ps
module dqi_top import dqi_pkg::*; #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic VALID_IN,
	input wire logic signed [W-1:0] I_IN,
	input wire logic signed [W-1:0] Q_IN,
	input wire logic MARK_IN,
	output logic VALID_OUT,
	output logic signed [W-1:0] I_OUT,
	output logic signed [W-1:0] Q_OUT,
	output logic MARK_OUT
);

	// ==========================================================
	// State
	typedef struct packed {
		logic en;
		dqi_unit_t unit;
		logic signed [15:0] leak_i;
		logic signed [15:0] leak_q;
		logic signed [7:0] imb;
		logic signed [15:0] quad;
		logic signed [4:0] skew;
		logic signed [3:0] dly;
		logic [3:0] phase;
		logic signed [15:0] pd_i;
		logic signed [15:0] pd_q;
		logic [31:0] rdata;
		logic signed [W-1:0] in_i;
		logic signed [W-1:0] in_q;
		logic signed [18:0] s2_i;
		logic signed [18:0] s2_q;
		logic signed [23:0] s2_off_i;
		logic signed [23:0] s2_off_q;
		logic signed [W-1:0] out_i;
		logic signed [W-1:0] out_q;
		logic [DQI_LAT-1:0] vpipe;
		logic [DQI_LAT-1:0] mpipe;
		logic [4:0] rst_cnt;
	} dqi_top_st_t;

	dqi_top_st_t st_reg;
	dqi_top_st_t st_next;

	logic [3:0] tap_i;
	logic [3:0] tap_q;
	logic signed [W-1:0] d_i;
	logic signed [W-1:0] d_q;
	logic signed [4:0] half_skew;
	logic signed [7:0] raw_i;
	logic signed [7:0] raw_q;
	logic signed [17:0] gain;
	logic signed [17:0] gain_pct;
	logic signed [15:0] quad_eff;
	logic signed [33:0] p_gq;
	logic signed [31:0] p_qx;
	logic signed [18:0] v_q;
	logic signed [34:0] p_lk_i;
	logic signed [34:0] p_lk_q;
	logic signed [18:0] lk_i;
	logic signed [18:0] lk_q;
	logic signed [17:0] cos_p;
	logic signed [17:0] sin_p;
	logic signed [36:0] p_ic;
	logic signed [36:0] p_qs;
	logic signed [36:0] p_is;
	logic signed [36:0] p_qc;
	logic signed [23:0] rot_i;
	logic signed [23:0] rot_q;
	logic signed [23:0] off_i;
	logic signed [23:0] off_q;

	function automatic logic [3:0] clamp_tap(input logic signed [7:0] v);
		if (v < 8'sd0) begin
			clamp_tap = 4'h0;
		end else if (v > 8'(DEPTH - 1)) begin
			clamp_tap = 4'(DEPTH - 1);
		end else begin
			clamp_tap = v[3:0];
		end
	endfunction : clamp_tap

	// ==========================================================
	// Tap selection for delay and skew
	assign half_skew = st_reg.skew >>> 1;
	assign raw_i = 8'(DQI_BASE_TAP) + 8'(st_reg.dly) - 8'(half_skew);
	assign raw_q = 8'(DQI_BASE_TAP) + 8'(st_reg.dly) + 8'(half_skew);
	assign tap_i = st_reg.en ? clamp_tap(raw_i) : 4'(DQI_BASE_TAP);
	assign tap_q = st_reg.en ? clamp_tap(raw_q) : 4'(DQI_BASE_TAP);

	dqi_dly #(.W(W), .DEPTH(DEPTH), .AW(4)) u_dly_i (
		.clk(REF_CLK),
		.srst(SRST),
		.din(st_reg.in_i),
		.tap(tap_i),
		.dout(d_i)
	);

	dqi_dly #(.W(W), .DEPTH(DEPTH), .AW(4)) u_dly_q (
		.clk(REF_CLK),
		.srst(SRST),
		.din(st_reg.in_q),
		.tap(tap_q),
		.dout(d_q)
	);

	// ==========================================================
	// Gain imbalance and quadrature
	assign gain_pct = DQI_UNITY + 18'(st_reg.imb) * DQI_PCT_STEP;
	assign gain = !st_reg.en ? DQI_UNITY :
		(st_reg.unit == DQI_UNIT_PCT) ? ((gain_pct < 18'sd0) ? 18'sd0 : gain_pct) :
		dqi_db_gain(st_reg.imb);
	assign quad_eff = st_reg.en ? st_reg.quad : 16'sd0;
	assign p_gq = d_q * gain;
	assign p_qx = d_i * quad_eff;
	assign v_q = 19'($signed(p_gq[31:14])) - 19'($signed(p_qx[31:14]));

	// ==========================================================
	// Leakage, phase rotation and predistortion
	assign p_lk_i = st_reg.leak_i * DQI_LEAK_SCALE;
	assign p_lk_q = st_reg.leak_q * DQI_LEAK_SCALE;
	assign lk_i = $signed(p_lk_i[34:16]);
	assign lk_q = $signed(p_lk_q[34:16]);
	assign sin_p = dqi_sin(st_reg.phase);
	assign cos_p = dqi_sin(4'(st_reg.phase + 4'h4));
	assign p_ic = lk_i * cos_p;
	assign p_qs = lk_q * sin_p;
	assign p_is = lk_i * sin_p;
	assign p_qc = lk_q * cos_p;
	assign rot_i = 24'($signed(p_ic[36:14])) - 24'($signed(p_qs[36:14]));
	assign rot_q = 24'($signed(p_is[36:14])) + 24'($signed(p_qc[36:14]));
	assign off_i = (st_reg.en ? rot_i : 24'sd0) + 24'(st_reg.pd_i);
	assign off_q = (st_reg.en ? rot_q : 24'sd0) + 24'(st_reg.pd_q);

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rdata = '0;
		if (WR) begin
			case (ADDR)
				DQI_CTRL_ADDR: begin
					st_next.en = WDATA[DQI_CTRL_EN_BIT];
					st_next.unit = WDATA[DQI_CTRL_PCT_BIT] ? DQI_UNIT_PCT : DQI_UNIT_DB;
				end
				DQI_LEAK_I_ADDR: st_next.leak_i = WDATA[15:0];
				DQI_LEAK_Q_ADDR: st_next.leak_q = WDATA[15:0];
				DQI_IMB_ADDR: st_next.imb = WDATA[7:0];
				DQI_QUAD_ADDR: st_next.quad = WDATA[15:0];
				DQI_SKEW_ADDR: st_next.skew = WDATA[4:0];
				DQI_DELAY_ADDR: st_next.dly = WDATA[3:0];
				DQI_PHASE_ADDR: st_next.phase = WDATA[3:0];
				DQI_PD_I_ADDR: st_next.pd_i = WDATA[15:0];
				DQI_PD_Q_ADDR: st_next.pd_q = WDATA[15:0];
				default: begin
				end
			endcase
		end
		if (RD) begin
			case (ADDR)
				DQI_CTRL_ADDR: begin
					st_next.rdata[DQI_CTRL_EN_BIT] = st_reg.en;
					st_next.rdata[DQI_CTRL_PCT_BIT] = (st_reg.unit == DQI_UNIT_PCT);
				end
				DQI_LEAK_I_ADDR: st_next.rdata[15:0] = st_reg.leak_i;
				DQI_LEAK_Q_ADDR: st_next.rdata[15:0] = st_reg.leak_q;
				DQI_IMB_ADDR: st_next.rdata[7:0] = st_reg.imb;
				DQI_QUAD_ADDR: st_next.rdata[15:0] = st_reg.quad;
				DQI_SKEW_ADDR: st_next.rdata[4:0] = st_reg.skew;
				DQI_DELAY_ADDR: st_next.rdata[3:0] = st_reg.dly;
				DQI_PHASE_ADDR: st_next.rdata[3:0] = st_reg.phase;
				DQI_PD_I_ADDR: st_next.rdata[15:0] = st_reg.pd_i;
				DQI_PD_Q_ADDR: st_next.rdata[15:0] = st_reg.pd_q;
				DQI_STAT_ADDR: begin
					st_next.rdata[DQI_STAT_EN_BIT] = st_reg.en;
					st_next.rdata[DQI_STAT_TI_POS +: 4] = tap_i;
					st_next.rdata[DQI_STAT_TQ_POS +: 4] = tap_q;
				end
				default: st_next.rdata = DQI_SET_RST;
			endcase
		end
		// Datapath, one pair per clock
		st_next.in_i = I_IN;
		st_next.in_q = Q_IN;
		st_next.s2_i = 19'(d_i);
		st_next.s2_q = v_q;
		st_next.s2_off_i = off_i;
		st_next.s2_off_q = off_q;
		st_next.out_i = dqi_sat16(25'(st_reg.s2_i) + 25'(st_reg.s2_off_i));
		st_next.out_q = dqi_sat16(25'(st_reg.s2_q) + 25'(st_reg.s2_off_q));
		st_next.vpipe = {st_reg.vpipe[DQI_LAT-2:0], VALID_IN};
		st_next.mpipe = {st_reg.mpipe[DQI_LAT-2:0], MARK_IN};
		if (st_reg.rst_cnt != 5'(DQI_LAT)) begin
			st_next.rst_cnt = 5'(st_reg.rst_cnt + 5'd1);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			st_reg <= '0;
			st_reg.en <= DQI_EN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RDATA = st_reg.rdata;
	assign VALID_OUT = st_reg.vpipe[DQI_LAT-1];
	assign MARK_OUT = st_reg.mpipe[DQI_LAT-1];
	assign I_OUT = st_reg.out_i;
	assign Q_OUT = st_reg.out_q;

	// ==========================================================
	// Checks
	rd_enable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(RD && ADDR == DQI_CTRL_ADDR) |=> (RDATA[DQI_CTRL_EN_BIT] == $past(st_reg.en)))
		else $error("control read does not show enable");

	rd_idle_zero_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!RD |=> (RDATA == 32'h0000_0000))
		else $error("read data not zero outside read answer");

	valid_latency_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.rst_cnt == 5'(DQI_LAT)) |-> (VALID_OUT == $past(VALID_IN, DQI_LAT)))
		else $error("valid latency wrong");

	marker_latency_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.rst_cnt == 5'(DQI_LAT)) |-> (MARK_OUT == $past(MARK_IN, DQI_LAT)))
		else $error("marker latency wrong");

	bypass_taps_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!st_reg.en |-> (tap_i == 4'(DQI_BASE_TAP) && tap_q == 4'(DQI_BASE_TAP)
			&& gain == DQI_UNITY && quad_eff == 16'sd0))
		else $error("settings act while disabled");

	skew_split_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.dly == 4'sd0 && st_reg.skew > 5'sd1 && st_reg.skew < 5'sd8)
		|-> (tap_q > tap_i && (tap_q - 4'(DQI_BASE_TAP)) == (4'(DQI_BASE_TAP) - tap_i)))
		else $error("skew not split evenly or wrong sign");

	skew_neg_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.dly == 4'sd0 && st_reg.skew < -5'sd1) |-> (tap_i > tap_q))
		else $error("negative skew does not delay I");

	delay_common_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.skew == 5'sd0)
		|-> (tap_i == tap_q && tap_i == clamp_tap(8'(DQI_BASE_TAP) + 8'(st_reg.dly))))
		else $error("common delay not applied to both");

	leak_zero_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.leak_i == 16'sd0 && st_reg.leak_q == 16'sd0) |-> (rot_i == 24'sd0 && rot_q == 24'sd0))
		else $error("zero leakage adds an offset");

	leak_own_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.phase == 4'h0)
		|-> (rot_i == 24'(lk_i) && rot_q == 24'(lk_q)))
		else $error("leakage crosses components at zero phase");

	predist_kept_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!st_reg.en |=> (st_reg.s2_off_i == 24'($past(st_reg.pd_i))
			&& st_reg.s2_off_q == 24'($past(st_reg.pd_q))))
		else $error("predistortion offset lost");

	gain_sign_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.unit == DQI_UNIT_DB && st_reg.imb != 8'sd0)
		|-> ((st_reg.imb > 8'sd0) == (gain > DQI_UNITY)))
		else $error("imbalance sign wrong");

	reset_clear_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		$past(SRST) |-> (!st_reg.en && st_reg.leak_i == 16'sd0 && st_reg.leak_q == 16'sd0
			&& st_reg.skew == 5'sd0 && st_reg.dly == 4'sd0 && st_reg.imb == 8'sd0))
		else $error("settings not cleared by reset");

	off_bypass_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!st_reg.en |-> (off_i == 24'(st_reg.pd_i) && off_q == 24'(st_reg.pd_q)))
		else $error("leakage acts while disabled");

	gain_unity_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.unit == DQI_UNIT_DB && st_reg.imb == 8'sd0) |-> (gain == DQI_UNITY))
		else $error("zero imbalance changes gain");

	pct_sign_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.unit == DQI_UNIT_PCT && st_reg.imb > 8'sd0) |-> (gain > DQI_UNITY))
		else $error("percent imbalance sign wrong");

	i_path_own_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		1'b1 |=> (st_reg.s2_i == 19'($past(d_i))))
		else $error("gain reaches the I path");

	quad_zero_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(quad_eff == 16'sd0) |-> (v_q == 19'($signed(p_gq[31:14]))))
		else $error("quadrature acts at zero setting");

	phase_quarter_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.phase == 4'h4) |-> (rot_i == -24'(lk_q) && rot_q == 24'(lk_i)))
		else $error("quarter turn phase wrong");

	leak_q_only_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.phase == 4'h0 && st_reg.leak_q == 16'sd0) |-> (rot_q == 24'sd0))
		else $error("I leakage reaches Q at zero phase");

	delay_pos_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.skew == 5'sd0 && st_reg.dly > 4'sd0)
		|-> (tap_i > 4'(DQI_BASE_TAP) && tap_q == tap_i))
		else $error("positive delay does not delay");

	delay_neg_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(st_reg.en && st_reg.skew == 5'sd0 && st_reg.dly < 4'sd0)
		|-> (tap_i < 4'(DQI_BASE_TAP) && tap_q == tap_i))
		else $error("negative delay does not advance");

	status_read_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(RD && ADDR == DQI_STAT_ADDR) |=> (RDATA[DQI_STAT_TI_POS +: 4] == $past(tap_i)
			&& RDATA[DQI_STAT_TQ_POS +: 4] == $past(tap_q)))
		else $error("status taps wrong");

	rd_upper_zero_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(RD && ADDR == DQI_IMB_ADDR) |=> (RDATA[31:8] == 24'h000000))
		else $error("upper read bits not zero");

endmodule : dqi_top
